//--- src/srd_pkg.sv
// Shared types and constants for the subroutine-return decoder
package srd_pkg;
  localparam int INSN_W = 14;
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  // Opcode patterns
  localparam logic [3:0] LIT_RET_HI = 4'hD;          // Bits 13:10 = 11 01
  localparam logic [13:0] PLAIN_RET_OP = 14'h0008;   // 00 0000 0000 1000
  localparam logic [13:0] NOP_OP = 14'h0000;
  localparam int LIT_LSB = 0;
  localparam int LIT_MSB = 7;
  localparam int HI_LSB = 10;
  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [1:0] PH_RST = 2'h0;
  // Phase indices within one instruction cycle (phase one is index 0)
  localparam logic [1:0] PH_ONE = 2'h0;
  localparam logic [1:0] PH_TWO = 2'h1;
  localparam logic [1:0] PH_FOUR = 2'h3;
  localparam int PHASES = 4;
  localparam int RET_CYCLES = 2;

  typedef enum logic [1:0] {
    SRD_IDLE = 2'b00,
    SRD_EXEC = 2'b01,
    SRD_DEAD = 2'b11
  } srd_state_t;

  typedef enum logic [1:0] {
    SRD_OP_OTHER = 2'b00,
    SRD_OP_LIT = 2'b01,
    SRD_OP_PLAIN = 2'b10
  } srd_op_t;

  // Return-stack handshake
  typedef struct packed {
    logic pop;
  } srd_stack_req_t;

  typedef struct packed {
    logic [12:0] top;
  } srd_stack_rsp_t;

  // Fetch-pipeline controls
  typedef struct packed {
    logic flush;
    logic hold;
    logic pc_load;
    logic [12:0] pc_value;
  } srd_fetch_ctl_t;
endpackage

//--- src/srd_opcode_match.sv
// Opcode classifier for the two return instructions
`timescale 1ns/1ps
module srd_opcode_match (
  input wire logic [srd_pkg::INSN_W-1:0] insn,
  output srd_pkg::srd_op_t op
);
  import srd_pkg::*;

  // Bits 9:8 of the literal form are don't-care
  always_comb begin
    if (insn[INSN_W-1:HI_LSB] == LIT_RET_HI) begin
      op = SRD_OP_LIT;
    end else if (insn == PLAIN_RET_OP) begin
      op = SRD_OP_PLAIN;
    end else begin
      op = SRD_OP_OTHER;
    end
  end
endmodule

//--- src/srd_decode.sv
// Decode and execution of the two subroutine-return instructions
//
// Contract
// - Literal return matches 11 01xx; low eight bits go to the accumulator.
// - Literal read in phase two, accumulator write and pop in phase four; second cycle idle.
// - Opcode 0x0008 is a plain return: pop stack into PC, flags untouched.
// - Plain return idles phases one to three, pops in phase four, second cycle idle.
`timescale 1ns/1ps
module srd_decode (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic insn_valid,
  input wire logic [srd_pkg::INSN_W-1:0] insn,
  input srd_pkg::srd_stack_rsp_t stack_rsp,
  output srd_pkg::srd_stack_req_t stack_req,
  output srd_pkg::srd_fetch_ctl_t fetch_ctl,
  output logic acc_we,
  output logic [srd_pkg::DATA_W-1:0] acc_wdata,
  output logic [1:0] phase,
  output logic busy
);
  import srd_pkg::*;

  typedef struct packed {
    srd_state_t st;
    logic [1:0] ph;
    srd_op_t op;
    logic [7:0] lit;
    logic [7:0] acc;
    logic acc_we;
    logic pop;
    logic pc_load;
    logic [12:0] pc_value;
  } srd_regs_t;

  srd_regs_t r_q;
  srd_regs_t r_d;
  srd_op_t dec_op;

  srd_opcode_match u_match (
    .insn(insn),
    .op(dec_op)
  );

  // Next-state: phases run continuously; a return is taken at phase one
  always_comb begin
    r_d = r_q;
    r_d.ph = r_q.ph + 2'h1;
    // Pulses default low so each one lasts exactly one clock
    r_d.acc_we = 1'b0;
    r_d.pop = 1'b0;
    r_d.pc_load = 1'b0;
    unique case (r_q.st)
      SRD_IDLE: begin
        if (r_q.ph == PH_ONE && insn_valid && dec_op != SRD_OP_OTHER) begin
          r_d.st = SRD_EXEC;
          r_d.op = dec_op;
        end
      end
      SRD_EXEC: begin
        // Literal latched in phase two so later fetches cannot disturb it
        if (r_q.ph == PH_TWO && r_q.op == SRD_OP_LIT) begin
          r_d.lit = insn[LIT_MSB:LIT_LSB];
        end
        // Phase four: pop stack for both; write accumulator for literal form
        if (r_q.ph == PH_FOUR) begin
          r_d.pop = 1'b1;
          r_d.pc_load = 1'b1;
          r_d.pc_value = stack_rsp.top;
          if (r_q.op == SRD_OP_LIT) begin
            r_d.acc = r_q.lit;
            r_d.acc_we = 1'b1;
          end
          r_d.st = SRD_DEAD;
        end
      end
      SRD_DEAD: begin
        // Whole second cycle does nothing
        if (r_q.ph == PH_FOUR) begin
          r_d.st = SRD_IDLE;
        end
      end
      default: begin
        r_d.st = SRD_IDLE;
      end
    endcase
    // Reset comes last so it overrides any step decoded in the same clock
    if (rst) begin
      r_d = '{
        st: SRD_IDLE,
        ph: PH_RST,
        op: SRD_OP_OTHER,
        lit: ACC_RST,
        acc: ACC_RST,
        acc_we: 1'b0,
        pop: 1'b0,
        pc_load: 1'b0,
        pc_value: PC_RST
      };
    end
  end

  // Single state register
  always_ff @(posedge ref_clk) begin
    r_q <= r_d;
  end

  // Pop pulses combinationally at phase four; the stack must present the top entry before
  assign stack_req.pop = r_q.st == SRD_EXEC && r_q.ph == PH_FOUR;
  // Fetch is held and the prefetched word is dropped until the idle cycle ends
  assign fetch_ctl.flush = r_q.st != SRD_IDLE;
  assign fetch_ctl.hold = r_q.st != SRD_IDLE;
  assign fetch_ctl.pc_load = r_q.pc_load;
  assign fetch_ctl.pc_value = r_q.pc_value;
  assign acc_we = r_q.acc_we;
  assign acc_wdata = r_q.acc;
  assign phase = r_q.ph;
  assign busy = r_q.st != SRD_IDLE;

  // Named steps of a return sequence
  sequence s_take;
    r_q.st == SRD_IDLE && r_q.ph == PH_ONE && insn_valid && dec_op != SRD_OP_OTHER;
  endsequence
  sequence s_pop_then_idle;
    stack_req.pop ##1 (busy && !stack_req.pop)[*4];
  endsequence
  sequence s_lit_take;
    s_take ##0 dec_op == SRD_OP_LIT;
  endsequence
  sequence s_plain_take;
    s_take ##0 dec_op == SRD_OP_PLAIN;
  endsequence
  // First cycle: two busy phases without a pop, then the pop in phase four
  sequence s_first_cycle;
    (busy && !stack_req.pop)[*2] ##1 stack_req.pop;
  endsequence
  // Second cycle: four busy phases with nothing popped
  sequence s_second_cycle;
    (busy && !stack_req.pop)[*4];
  endsequence

  // Pop lands three clocks after the take, then a full idle cycle
  a_pop_at_four: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |-> ##3 s_pop_then_idle ##1 !busy)
    else $error("return did not pop in phase four then idle one cycle");

  // No pop may fall outside phase four
  a_pop_phase: assert property (@(posedge ref_clk) disable iff (rst)
    stack_req.pop |-> phase == PH_FOUR)
    else $error("stack pop outside phase four");

  // Literal re-read in phase two must be the word that reaches the accumulator
  a_lit_write: assert property (@(posedge ref_clk) disable iff (rst)
    (s_lit_take ##1 $stable(insn))
      |-> ##3 (acc_we && acc_wdata == $past(insn[LIT_MSB:LIT_LSB], 3)))
    else $error("accumulator not loaded with literal");

  // Plain return leaves the accumulator alone for the five clocks after the take
  a_plain_noacc: assert property (@(posedge ref_clk) disable iff (rst)
    (s_take ##0 insn == PLAIN_RET_OP) |-> ##1 !acc_we[*5])
    else $error("plain return touched the accumulator");

  // Program counter takes the entry that stood on the stack at the pop
  a_pc_from_top: assert property (@(posedge ref_clk) disable iff (rst)
    stack_req.pop |=> fetch_ctl.pc_load && fetch_ctl.pc_value == $past(stack_rsp.top))
    else $error("program counter not loaded from stack top");

  // Discard spans the rest of both cycles, so the next slot is free for a fetch
  a_flush_span: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |=> fetch_ctl.flush[*7] ##1 !fetch_ctl.flush)
    else $error("prefetch not discarded for exactly two cycles");

  // Accumulator strobe only follows a literal-return pop
  a_acc_only_lit: assert property (@(posedge ref_clk) disable iff (rst)
    acc_we |-> $past(stack_req.pop) && r_q.op == SRD_OP_LIT)
    else $error("accumulator written outside literal return");

  // Words outside the two encodings never start a return
  a_other_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    (r_q.st == SRD_IDLE && phase == PH_ONE && insn_valid && insn[13:10] != LIT_RET_HI
     && insn != PLAIN_RET_OP) |=> !busy)
    else $error("non-return opcode started a return");

  // Whole two-cycle shape of either return, phase by phase
  a_two_cycle_shape: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |=> s_first_cycle ##1 s_second_cycle ##1 !busy)
    else $error("return did not follow the two-cycle phase pattern");

  // Fetch is frozen from the clock after the take
  a_take_hold: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |=> (fetch_ctl.hold && fetch_ctl.flush))
    else $error("fetch not held after a return was taken");

  // Fetch may restart at the phase-one slot that follows the idle cycle
  a_resume_slot: assert property (@(posedge ref_clk) disable iff (rst)
    s_take |-> ##8 (!busy && phase == PH_ONE))
    else $error("fetch slot not free after the idle cycle");

  // Accumulator value only moves on a literal-return write
  a_acc_hold: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(acc_wdata) |-> acc_we)
    else $error("accumulator changed without a write");

  // Program counter value only moves on a load
  a_pc_hold: assert property (@(posedge ref_clk) disable iff (rst)
    $changed(fetch_ctl.pc_value) |-> fetch_ctl.pc_load)
    else $error("program counter value changed without a load");

  // Phase counter steps once per clock; every timing rule leans on it
  a_phase_step: assert property (@(posedge ref_clk) disable iff (rst)
    1'b1 |=> phase == 2'($past(phase) + 2'h1))
    else $error("phase counter skipped or stalled");

  // A return word offered during the idle cycle must not start a second pop
  a_busy_refuse: assert property (@(posedge ref_clk) disable iff (rst)
    (busy && phase == PH_ONE) |=> (!stack_req.pop)[*3])
    else $error("second pop while a return was still running");

  // Each return loads the program counter; only the literal form writes the accumulator
  a_lit_load: assert property (@(posedge ref_clk) disable iff (rst)
    s_lit_take |-> ##4 (fetch_ctl.pc_load && acc_we))
    else $error("literal return did not load counter and accumulator together");
  a_plain_load: assert property (@(posedge ref_clk) disable iff (rst)
    s_plain_take |-> ##4 (fetch_ctl.pc_load && !acc_we))
    else $error("plain return load step wrong");

  // The clocks after the load stay quiet until the idle cycle ends
  a_second_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    fetch_ctl.pc_load |=> (!fetch_ctl.pc_load && !acc_we && !stack_req.pop)[*3])
    else $error("activity inside the idle second cycle");
endmodule

//--- test/tb_top.sv
// Self-checking bench for the subroutine-return decoder
`timescale 1ns/1ps
module tb_top;
  import srd_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic insn_valid = 1'b0;
  logic [13:0] insn = NOP_OP;
  srd_stack_rsp_t stack_rsp = '0;
  srd_stack_req_t stack_req;
  srd_fetch_ctl_t fetch_ctl;
  logic acc_we;
  logic [7:0] acc_wdata;
  logic [1:0] phase;
  logic busy;
  int failures = 0;
  int n_compared = 0;
  srd_decode u_srd_decode (.ref_clk(ref_clk), .rst(rst), .insn_valid(insn_valid), .insn(insn),
    .stack_rsp(stack_rsp), .stack_req(stack_req), .fetch_ctl(fetch_ctl), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .phase(phase), .busy(busy));
  // 200 MHz core clock, one clock per phase
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Four-state compare, so an unknown never passes
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for an idle phase-zero slot
  task automatic to_slot();
    int i;
    for (i = 0; i < 20 && !(phase === PH_ONE && busy === 1'b0); i++) @(negedge ref_clk);
    if (i == 20) begin
      failures++;
      wrap_up();
    end
  endtask
  // Offer one word in a slot and watch the nine clocks after the take
  task automatic issue(input logic [13:0] w, input logic [12:0] top, input logic lit, input logic taken);
    int n_pop = 0;
    int n_ld = 0;
    int n_we = 0;
    int n_fl = 0;
    logic [1:0] ph_pop;
    logic [1:0] ph_ld;
    logic [7:0] acc0;
    acc0 = acc_wdata;
    to_slot();
    insn = w;
    insn_valid = 1'b1;
    stack_rsp.top = top;
    @(negedge ref_clk);
    // Word stays on insn so the literal re-read at phase two sees it
    insn_valid = 1'b0;
    repeat (9) begin
      if (fetch_ctl.flush === 1'b1 && fetch_ctl.hold === 1'b1) n_fl++;
      if (stack_req.pop === 1'b1) begin
        n_pop++;
        ph_pop = phase;
      end
      if (fetch_ctl.pc_load === 1'b1) begin
        n_ld++;
        ph_ld = phase;
        chk(16'(fetch_ctl.pc_value), 16'(top));
      end
      if (acc_we === 1'b1) n_we++;
      @(negedge ref_clk);
    end
    if (taken) begin
      chk(16'(n_pop), 16'h0001);
      chk(16'(ph_pop), 16'(PH_FOUR));
      chk(16'(ph_ld), 16'(PH_ONE));
      chk(16'(n_we), 16'(lit));
      chk(16'(n_ld), 16'h0001);
      chk(16'(n_fl), 16'h0007);
    end else begin
      chk(16'(n_pop + n_ld + n_we + n_fl), 16'h0000);
    end
    chk(16'(acc_wdata), 16'((lit && taken) ? w[7:0] : acc0));
    $display("Test done: insn %h", w);
  endtask
  // A valid word offered off phase zero must be ignored
  task automatic off_slot();
    int n_busy = 0;
    to_slot();
    @(negedge ref_clk);
    insn = 14'h3511;
    insn_valid = 1'b1;
    @(negedge ref_clk);
    insn_valid = 1'b0;
    repeat (8) begin
      if (busy !== 1'b0) n_busy++;
      @(negedge ref_clk);
    end
    chk(16'(n_busy), 16'h0000);
    $display("Test done: off-slot request");
  endtask
  // Main sequence
  initial begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    issue(14'h37A5, 13'h1ABC, 1'b1, 1'b1);
    issue(14'h345A, 13'h0123, 1'b1, 1'b1);
    issue(PLAIN_RET_OP, 13'h0FF0, 1'b0, 1'b1);
    issue(14'h0009, 13'h0555, 1'b0, 1'b0);
    issue(14'h3CA5, 13'h0AAA, 1'b1, 1'b0);
    issue(14'h2DA5, 13'h0AAA, 1'b1, 1'b0);
    off_slot();
    wrap_up();
  end
endmodule
